// File: common/emsi_pkg.sv
/*
 emsi_pkg: constants and types of the external memory strobe interface.
 assumes one 125 MHz reference clock and word addressed requests.
*/
// What this block does
// - program width pin high means 16-bit program
// - 16-bit program fetch takes two halves
// - strobe group active only for its range
// - each group has physical and data widths
// - data width may differ from physical width
// - 8-bit: lanes 3,2 address, lane0 select
// - 16-bit: lane3 address, lanes 0,1 select
// - 32-bit: all four lanes are byte enables
// - io strobe single signal, 32-bit only
// - io strobe cycles longer than group cycles
// - fixed address ranges per strobe group
// - internal ram served without external strobes
// - width configuration changeable at run time
// - three independent external areas
// - deep idle: bus idle, phase clocks frozen
// - reduced clock runs at one sixteenth rate
// - bus cycle stretched until ready low
// - hold low floats bus and grants in the same cycle
// - read-not-write high reads, low writes
// - program width pin sets control reset value
package emsi_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int REQ_W = 58;
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] WID_8 = 2'h0;
	localparam logic [1:0] WID_16 = 2'h1;
	localparam logic [1:0] WID_32 = 2'h2;
	localparam logic [23:0] PRI_LO_END = 24'h7F_FFFF;
	localparam logic [23:0] IO_BASE = 24'h81_0000;
	localparam logic [23:0] IO_END = 24'h82_FFFF;
	localparam logic [23:0] RAM_BASE = 24'h87_FE00;
	localparam logic [23:0] RAM_END = 24'h87_FFFF;
	localparam logic [23:0] PRI_HI_BASE = 24'h88_0000;
	localparam logic [23:0] PRI_HI_END = 24'h8F_FFFF;
	localparam logic [23:0] SEC_BASE = 24'h90_0000;
	localparam int RAM_WORDS = 512;
	localparam int RAM_IDX_W = 9;
	localparam logic [2:0] STRB_WAIT = 3'h1;
	localparam logic [2:0] IO_WAIT = 3'h2;
	localparam logic [3:0] LOWPWR_LAST = 4'hF;
	localparam logic [3:0] STRB_OFF = 4'hF;
	typedef enum logic [1:0] {
		GRP_PRI = 2'b00,
		GRP_SEC = 2'b01,
		GRP_IO = 2'b10,
		GRP_NONE = 2'b11
	} emsi_grp_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NEXT = 2'b01,
		ST_ACCESS = 2'b10,
		ST_HOLD = 2'b11
	} emsi_state_t;
endpackage : emsi_pkg

// File: verilog/emsi_fifo.sv
/*
 emsi_fifo: request fifo with valid/ready on both sides.
 assumes a single clock; ready and valid come from flops.
*/
`timescale 1ns/10ps
module emsi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, rd_r;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_ready_i && out_valid_o;
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem_r[rd_r];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(pop);
			cnt_r <= cnt_nxt;
			// ready comes from the next count, so it drops as the last word enters and full is exact
			in_ready_o <= cnt_nxt != (AW+1)'(DEPTH);
			out_valid_o <= cnt_nxt != '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end
endmodule : emsi_fifo

// File: verilog/emsi_clkgen.sv
/*
 emsi_clkgen: phase clock outputs, reduced rate tick and deep idle.
 assumes enter_idle_i only while the bus engine is idle.
*/
`timescale 1ns/10ps
module emsi_clkgen import emsi_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic enter_idle_i,
	input wire logic reduced_i,
	input wire logic [3:0] irq_i,
	output logic tick_o,
	output logic h1_o,
	output logic h3_o
);
	logic idle_r, idle_nxt, tick_nxt;
	logic [3:0] div_r;

	assign idle_nxt = idle_r ? ~|irq_i : enter_idle_i;
	assign tick_nxt = !idle_nxt && (!reduced_i || div_r == LOWPWR_LAST);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idle_r <= 1'b0;
			div_r <= '0;
			tick_o <= 1'b0;
			h1_o <= 1'b0;
			h3_o <= 1'b1;
		end else begin
			idle_r <= idle_nxt;
			div_r <= reduced_i ? div_r + 4'h1 : '0;
			tick_o <= tick_nxt;
			h1_o <= idle_nxt ? 1'b1 : (tick_nxt ? ~h1_o : h1_o);
			h3_o <= idle_nxt ? 1'b0 : (tick_nxt ? h1_o : h3_o);
		end
	end

	property p_idle_clocks;
		@(posedge clk_i) disable iff (!rst_b_i) idle_r |-> h1_o && !h3_o;
	endproperty
	a_idle_clocks: assert property (p_idle_clocks) else $error("phase clocks not frozen");
	property p_slow_tick;
		@(posedge clk_i) disable iff (!rst_b_i)
			(tick_o && reduced_i) |=> (!tick_o || !reduced_i)[*8];
	endproperty
	a_slow_tick: assert property (p_slow_tick) else $error("reduced tick too fast");
endmodule : emsi_clkgen

// File: verilog/emsi_top.sv
/*
 emsi_top: external memory strobe interface, request fifo to pins.
 assumes requests synchronous to ref_clk_i; pins resolved outside.
*/
`timescale 1ns/10ps
module emsi_top import emsi_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_fetch_i,
	input wire logic [23:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	output logic req_ready_o,
	output logic resp_valid_o,
	output logic resp_err_o,
	output logic [31:0] resp_rdata_o,
	input wire logic cfg_write_i,
	input wire logic cfg_sel_i,
	input wire logic [1:0] cfg_phys_width_i,
	input wire logic [1:0] cfg_data_width_i,
	output logic [3:0] pri_cfg_o,
	output logic [3:0] sec_cfg_o,
	input wire logic program_width_select_i,
	input wire logic deep_idle_mode_i,
	input wire logic reduced_clock_mode_i,
	input wire logic [3:0] ext_irq_i,
	input wire logic hold_b_i,
	input wire logic rdy_b_i,
	output logic [23:0] addr_o,
	output logic bus_oe_o,
	output logic read_not_write_o,
	output logic [3:0] primary_memory_strobe_group_b_o,
	output logic [3:0] secondary_memory_strobe_group_b_o,
	output logic peripheral_io_strobe_b_o,
	output logic [31:0] data_o,
	output logic data_oe_o,
	input wire logic [31:0] data_i,
	output logic bus_release_grant_b_o,
	output logic phase_one_clock_out_o,
	output logic phase_three_clock_out_o
);
	////////////////////////////////////////////////////////////////////////////
	function automatic emsi_grp_t region(input logic [23:0] a);
		if (a <= PRI_LO_END || (a >= PRI_HI_BASE && a <= PRI_HI_END)) begin
			region = GRP_PRI;
		end else if (a >= IO_BASE && a <= IO_END) begin
			region = GRP_IO;
		end else if (a >= SEC_BASE) begin
			region = GRP_SEC;
		end else begin
			region = GRP_NONE;
		end
	endfunction : region

	function automatic logic [1:0] clip(input logic [1:0] w);
		clip = (w > WID_32) ? WID_32 : w;
	endfunction : clip

	function automatic logic [3:0] lane_mask(input logic [1:0] nlog, input logic [1:0] off);
		case (nlog)
			WID_8: lane_mask = 4'h1 << off;
			WID_16: lane_mask = 4'h3 << off;
			default: lane_mask = 4'hF;
		endcase
	endfunction : lane_mask

	function automatic logic [3:0] group_pins(input logic [1:0] plog, input logic [3:0] m,
		input logic [1:0] b);
		case (plog)
			WID_8: group_pins = {b[1], b[0], 1'b1, ~m[0]};
			WID_16: group_pins = {b[1], 1'b1, ~m[1:0]};
			default: group_pins = ~m;
		endcase
	endfunction : group_pins

	////////////////////////////////////////////////////////////////////////////
	logic f_valid, f_pop, f_write, f_fetch, f_ram;
	logic [REQ_W-1:0] f_data;
	logic [23:0] f_addr;
	logic [31:0] f_wdata;
	emsi_grp_t f_grp;
	logic tick;
	emsi_state_t st_r, st_nxt;
	logic init_r;
	logic [1:0] pri_pw_r, pri_dw_r, sec_pw_r, sec_dw_r;
	logic [23:0] rq_addr_r;
	logic [31:0] rq_wdata_r, rd_acc_r, acc_nxt, wbus;
	logic rq_write_r;
	emsi_grp_t rq_grp_r;
	logic [1:0] rq_plog_r, rq_dlog_r, beat_r, nlog, off, last_beat;
	logic [2:0] wait_r;
	logic [25:0] base, bk;
	logic [3:0] lmask, pins;
	logic beat_done, is_last;
	logic [31:0] ram_r [RAM_WORDS];

	assign {f_write, f_fetch, f_addr, f_wdata} = f_data;
	assign f_grp = region(f_addr);
	assign f_ram = f_addr >= RAM_BASE && f_addr <= RAM_END;
	assign f_pop = st_r == ST_IDLE && tick && f_valid && hold_b_i && init_r;

	emsi_fifo #(
		.W(REQ_W),
		.DEPTH(FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(req_valid_i),
		.in_data_i({req_write_i, req_fetch_i, req_addr_i, req_wdata_i}),
		.in_ready_o(req_ready_o),
		.out_valid_o(f_valid),
		.out_data_o(f_data),
		.out_ready_i(f_pop)
	);

	emsi_clkgen u_clk (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.enter_idle_i(deep_idle_mode_i && st_r == ST_IDLE),
		.reduced_i(reduced_clock_mode_i),
		.irq_i(ext_irq_i),
		.tick_o(tick),
		.h1_o(phase_one_clock_out_o),
		.h3_o(phase_three_clock_out_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// control registers; the width pin seeds them right after reset
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			init_r <= 1'b0;
			pri_pw_r <= WID_32;
			pri_dw_r <= WID_32;
			sec_pw_r <= WID_32;
			sec_dw_r <= WID_32;
		end else if (!init_r) begin
			init_r <= 1'b1;
			pri_pw_r <= program_width_select_i ? WID_16 : WID_32;
			pri_dw_r <= WID_32;
			sec_pw_r <= program_width_select_i ? WID_16 : WID_32;
			sec_dw_r <= WID_32;
		end else if (cfg_write_i && !cfg_sel_i) begin
			pri_pw_r <= cfg_phys_width_i;
			pri_dw_r <= cfg_data_width_i;
		end else if (cfg_write_i) begin
			sec_pw_r <= cfg_phys_width_i;
			sec_dw_r <= cfg_data_width_i;
		end
	end

	assign pri_cfg_o = {pri_pw_r, pri_dw_r};
	assign sec_cfg_o = {sec_pw_r, sec_dw_r};

	////////////////////////////////////////////////////////////////////////////
	assign beat_done = st_r == ST_ACCESS && tick && wait_r == '0 && !rdy_b_i;
	assign last_beat = (rq_dlog_r > rq_plog_r) ?
		2'((3'h1 << (rq_dlog_r - rq_plog_r)) - 3'h1) : 2'h0;
	assign is_last = beat_r == last_beat;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (!hold_b_i) begin
					st_nxt = ST_HOLD;
				end else if (f_pop && !f_ram && f_grp != GRP_NONE) begin
					st_nxt = ST_NEXT;
				end
			end
			ST_NEXT: begin
				if (tick) begin
					st_nxt = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (beat_done) begin
					st_nxt = is_last ? ST_IDLE : ST_NEXT;
				end
			end
			ST_HOLD: begin
				if (hold_b_i) begin
					st_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latch the request and pick its widths
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rq_addr_r <= '0;
			rq_wdata_r <= '0;
			rq_write_r <= 1'b0;
			rq_grp_r <= GRP_NONE;
			rq_plog_r <= WID_32;
			rq_dlog_r <= WID_32;
		end else if (f_pop) begin
			rq_addr_r <= f_addr;
			rq_wdata_r <= f_wdata;
			rq_write_r <= f_write;
			rq_grp_r <= f_grp;
			if (f_grp == GRP_IO) begin
				rq_plog_r <= WID_32;
				rq_dlog_r <= WID_32;
			end else if (f_fetch) begin
				rq_plog_r <= program_width_select_i ? WID_16 : WID_32;
				rq_dlog_r <= WID_32;
			end else if (f_grp == GRP_SEC) begin
				rq_plog_r <= clip(sec_pw_r);
				rq_dlog_r <= clip(sec_dw_r);
			end else begin
				rq_plog_r <= clip(pri_pw_r);
				rq_dlog_r <= clip(pri_dw_r);
			end
		end
	end

	// byte address, lanes and data placement of the current beat
	always_comb begin
		nlog = (rq_plog_r < rq_dlog_r) ? rq_plog_r : rq_dlog_r;
		base = 26'({2'b00, rq_addr_r} << rq_dlog_r);
		bk = base + 26'(26'(beat_r) << rq_plog_r);
		case (rq_plog_r)
			WID_8: off = 2'h0;
			WID_16: off = {1'b0, bk[0]};
			default: off = bk[1:0];
		endcase
		lmask = lane_mask(nlog, off);
		pins = group_pins(rq_plog_r, lmask, bk[1:0]);
		wbus = '0;
		acc_nxt = rd_acc_r;
		for (int i = 0; i < 4; i++) begin
			if (i < (1 << nlog)) begin
				wbus[8*(int'(off)+i) +: 8] = rq_wdata_r[8*(int'(beat_r)*(1 << nlog)+i) +: 8];
				acc_nxt[8*(int'(beat_r)*(1 << nlog)+i) +: 8] = data_i[8*(int'(off)+i) +: 8];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			beat_r <= '0;
			wait_r <= '0;
			rd_acc_r <= '0;
		end else if (f_pop) begin
			beat_r <= '0;
			rd_acc_r <= '0;
		end else if (st_r == ST_NEXT && tick) begin
			wait_r <= (rq_grp_r == GRP_IO) ? IO_WAIT : STRB_WAIT;
		end else if (st_r == ST_ACCESS && tick) begin
			if (wait_r != '0) begin
				wait_r <= wait_r - 3'h1;
			end else if (!rdy_b_i) begin
				beat_r <= beat_r + 2'h1;
				rd_acc_r <= acc_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins; strobes fall in the same tick that the address is driven
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_o <= '0;
			read_not_write_o <= 1'b1;
			primary_memory_strobe_group_b_o <= STRB_OFF;
			secondary_memory_strobe_group_b_o <= STRB_OFF;
			peripheral_io_strobe_b_o <= 1'b1;
			data_o <= '0;
			data_oe_o <= 1'b0;
		end else if (st_r == ST_NEXT && tick) begin
			addr_o <= bk[25:2];
			read_not_write_o <= !rq_write_r;
			data_o <= wbus;
			data_oe_o <= rq_write_r;
			unique case (rq_grp_r)
				GRP_PRI: primary_memory_strobe_group_b_o <= pins;
				GRP_SEC: secondary_memory_strobe_group_b_o <= pins;
				GRP_IO: peripheral_io_strobe_b_o <= 1'b0;
				GRP_NONE: peripheral_io_strobe_b_o <= 1'b1;
			endcase
		end else if (beat_done || st_nxt == ST_HOLD) begin
			primary_memory_strobe_group_b_o <= STRB_OFF;
			secondary_memory_strobe_group_b_o <= STRB_OFF;
			peripheral_io_strobe_b_o <= 1'b1;
			read_not_write_o <= 1'b1;
			data_oe_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_oe_o <= 1'b1;
			bus_release_grant_b_o <= 1'b1;
		end else begin
			bus_oe_o <= st_nxt != ST_HOLD;
			bus_release_grant_b_o <= st_nxt != ST_HOLD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// internal ram is answered here, the pins never move
	always_ff @(posedge ref_clk_i) begin
		if (f_pop && f_ram && f_write) begin
			ram_r[f_addr[RAM_IDX_W-1:0]] <= f_wdata;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			resp_valid_o <= 1'b0;
			resp_err_o <= 1'b0;
			resp_rdata_o <= '0;
		end else if (f_pop && (f_ram || f_grp == GRP_NONE)) begin
			resp_valid_o <= 1'b1;
			resp_err_o <= !f_ram;
			resp_rdata_o <= (f_ram && !f_write) ? ram_r[f_addr[RAM_IDX_W-1:0]] : '0;
		end else if (beat_done && is_last) begin
			resp_valid_o <= 1'b1;
			resp_err_o <= 1'b0;
			resp_rdata_o <= rq_write_r ? '0 : acc_nxt;
		end else begin
			resp_valid_o <= 1'b0;
			resp_err_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	property p_strobe_idle;
		st_r != ST_ACCESS |-> primary_memory_strobe_group_b_o == STRB_OFF &&
			secondary_memory_strobe_group_b_o == STRB_OFF && peripheral_io_strobe_b_o;
	endproperty
	a_strobe_idle: assert property (p_strobe_idle) else $error("strobe outside access");
	property p_rw;
		st_r == ST_ACCESS |-> read_not_write_o == !rq_write_r && data_oe_o == rq_write_r;
	endproperty
	a_rw: assert property (p_rw) else $error("read-not-write wrong");
	property p_lane1_8;
		st_r == ST_ACCESS && rq_grp_r == GRP_SEC && rq_plog_r == WID_8
			|-> secondary_memory_strobe_group_b_o[1] && secondary_memory_strobe_group_b_o[3] == bk[1];
	endproperty
	a_lane1_8: assert property (p_lane1_8) else $error("8-bit lane use wrong");
	property p_lane2_16;
		st_r == ST_ACCESS && rq_grp_r == GRP_SEC && rq_plog_r == WID_16
			|-> secondary_memory_strobe_group_b_o[2];
	endproperty
	a_lane2_16: assert property (p_lane2_16) else $error("16-bit lane2 driven");
	property p_io_len;
		$fell(peripheral_io_strobe_b_o) |-> (!peripheral_io_strobe_b_o)[*3];
	endproperty
	a_io_len: assert property (p_io_len) else $error("io strobe too short");
	property p_ready;
		st_r == ST_ACCESS && wait_r == '0 && rdy_b_i |=> st_r == ST_ACCESS;
	endproperty
	a_ready: assert property (p_ready) else $error("cycle ended without ready");
	property p_hold;
		!bus_release_grant_b_o |-> !bus_oe_o && !data_oe_o && st_r == ST_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("grant while bus driven");
	property p_ram;
		f_pop && f_ram |=> (st_r == ST_IDLE && peripheral_io_strobe_b_o &&
			primary_memory_strobe_group_b_o == STRB_OFF && resp_valid_o && !resp_err_o);
	endproperty
	a_ram: assert property (p_ram) else $error("internal ram went external");
	property p_fetch16;
		f_pop && f_fetch && program_width_select_i && (f_grp == GRP_PRI || f_grp == GRP_SEC)
			&& !f_ram |=> rq_plog_r == WID_16 && rq_dlog_r == WID_32 && last_beat == 2'h1;
	endproperty
	a_fetch16: assert property (p_fetch16) else $error("half-word fetch not split");

	c_io: cover property ($fell(peripheral_io_strobe_b_o));
	c_hold: cover property ($fell(bus_release_grant_b_o));
	c_split: cover property (beat_done && !is_last);
	c_ram: cover property (f_pop && f_ram);
endmodule : emsi_top

// File: dv/emsi_mem_model.sv
/*
 emsi_mem_model: external memory and slow peripheral behind the strobe pins.
 assumes pins already resolved; ready delay set by the bench.
*/
`timescale 1ns/10ps
module emsi_mem_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] dly_i,
	input wire logic [23:0] addr_i,
	input wire logic bus_oe_i,
	input wire logic rnw_i,
	input wire logic [3:0] pri_b_i,
	input wire logic [3:0] sec_b_i,
	input wire logic io_b_i,
	input wire logic [31:0] wdata_i,
	output logic rdy_b_o,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [logic [27:0]];
	logic [27:0] key;
	logic act;
	logic [3:0] cnt_r;
	logic [31:0] last_r;
	////////////////////////////////////////////////////////////////////////////////
	// lane pins of the active group serve as low address bits on narrow memory
	assign act = bus_oe_i & (~&pri_b_i | ~&sec_b_i | ~io_b_i);
	assign key = {~&sec_b_i, ~io_b_i, addr_i, pri_b_i[3:2] & sec_b_i[3:2]};
	assign rdy_b_o = ~(act && cnt_r >= dly_i);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
		end else if (!act) begin
			cnt_r <= 4'h0;
		end else if (cnt_r != 4'hF) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	always @(posedge clk_i) begin
		last_r <= rdata_o;
		if (act && !rdy_b_o && !rnw_i) begin
			mem[key] = wdata_i;
		end
	end
	// released bus toggles each cycle between the inverse of the last read value and that value
	always @* begin
		if (act && rnw_i && mem.exists(key)) begin
			rdata_o = mem[key];
		end else begin
			rdata_o = ~last_r;
		end
	end
endmodule : emsi_mem_model

// File: dv/emsi_top_tb.sv
/*
 emsi_top_tb: scenario bench for the external memory strobe interface.
 assumes emsi_mem_model answers on the far side of the pins.
*/
`timescale 1ns/10ps
module emsi_top_tb import emsi_pkg::*; ();
	logic ref_clk = 0, rst_b = 0, req_valid = 0, req_write = 0, req_fetch = 0;
	logic [23:0] req_addr = 0, addr;
	logic [31:0] req_wdata = 0, rdata, data_o, data_i, rd;
	logic req_ready, resp_valid, resp_err, err, cfg_write = 0, cfg_sel = 0, pgm_w = 0;
	logic [1:0] cfg_pw = 0, cfg_dw = 0;
	logic [3:0] pri_cfg, sec_cfg, irq = 0, pri_b, sec_b, snap_pri, snap_sec, dly = 1;
	logic deep = 0, reduced = 0, hold_b = 1, rdy_b, bus_oe, rnw, io_b, data_oe;
	logic grant_b, h1, h3, snap_io, snap_rw, act_q = 1'b0;
	logic [23:0] snap_addr;
	int miscompares = 0, comparisons = 0, beats, lat, lat_pri;
	always #4 ref_clk = ~ref_clk;
	emsi_top u_emsi_top (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .req_valid_i(req_valid),
		.req_write_i(req_write), .req_fetch_i(req_fetch), .req_addr_i(req_addr),
		.req_wdata_i(req_wdata), .req_ready_o(req_ready), .resp_valid_o(resp_valid),
		.resp_err_o(resp_err), .resp_rdata_o(rdata), .cfg_write_i(cfg_write),
		.cfg_sel_i(cfg_sel), .cfg_phys_width_i(cfg_pw), .cfg_data_width_i(cfg_dw),
		.pri_cfg_o(pri_cfg), .sec_cfg_o(sec_cfg), .program_width_select_i(pgm_w),
		.deep_idle_mode_i(deep), .reduced_clock_mode_i(reduced), .ext_irq_i(irq),
		.hold_b_i(hold_b), .rdy_b_i(rdy_b), .addr_o(addr), .bus_oe_o(bus_oe),
		.read_not_write_o(rnw), .primary_memory_strobe_group_b_o(pri_b),
		.secondary_memory_strobe_group_b_o(sec_b), .peripheral_io_strobe_b_o(io_b),
		.data_o(data_o), .data_oe_o(data_oe), .data_i(data_i),
		.bus_release_grant_b_o(grant_b), .phase_one_clock_out_o(h1),
		.phase_three_clock_out_o(h3));
	emsi_mem_model u_emsi_mem_model (.clk_i(ref_clk), .rst_b_i(rst_b), .dly_i(dly),
		.addr_i(addr), .bus_oe_i(bus_oe), .rnw_i(rnw), .pri_b_i(pri_b), .sec_b_i(sec_b),
		.io_b_i(io_b), .wdata_i(data_o), .rdy_b_o(rdy_b), .rdata_o(data_i));
	////////////////////////////////////////////////////////////////////////////////
	// beat monitor: one beat per strobe activation; ready may fall early in wait states
	always @(posedge ref_clk) begin
		act_q <= bus_oe && (~&pri_b || ~&sec_b || ~io_b);
		if (bus_oe && (~&pri_b || ~&sec_b || ~io_b) && !act_q) begin
			beats++;
			snap_pri = pri_b;
			snap_sec = sec_b;
			snap_io = io_b;
			snap_rw = rnw;
			snap_addr = addr;
		end
	end
	always begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// one request through the fifo, waits for its response pulse
	task automatic xfer(input logic wr, input logic fe, input logic [23:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		beats = 0;
		req_valid <= 1'b1;
		req_write <= wr;
		req_fetch <= fe;
		req_addr <= a;
		req_wdata <= wd;
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (lat = 1; lat < 400; lat++) begin
			@(negedge ref_clk);
			if (resp_valid === 1'b1) break;
		end
		check({31'h0, resp_valid}, 32'h1, "response");
		rd = rdata;
		err = resp_err;
	endtask : xfer
	task automatic cfg(input logic sel, input logic [1:0] pw, input logic [1:0] dw);
		@(posedge ref_clk);
		cfg_write <= 1'b1;
		cfg_sel <= sel;
		cfg_pw <= pw;
		cfg_dw <= dw;
		@(posedge ref_clk);
		cfg_write <= 1'b0;
		@(negedge ref_clk);
		check({28'h0, sel ? sec_cfg : pri_cfg}, {28'h0, pw, dw}, "cfg");
	endtask : cfg
	task automatic do_reset();
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(negedge ref_clk);
		check({28'h0, pri_cfg}, {28'h0, pgm_w ? WID_16 : WID_32, WID_32}, "pri rst");
		check({28'h0, sec_cfg}, {28'h0, pgm_w ? WID_16 : WID_32, WID_32}, "sec rst");
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		// primary 32/32 word write and read back
		xfer(1'b1, 1'b0, 24'h00_0010, 32'hA5A5_1234);
		check({28'h0, snap_pri}, 32'h0, "pri lanes");
		check({28'h0, snap_sec}, 32'hF, "sec idle");
		check({31'h0, snap_rw}, 32'h0, "rw write");
		check({8'h0, snap_addr}, 32'h10, "addr");
		xfer(1'b0, 1'b0, 24'h00_0010, 32'h0);
		lat_pri = lat;
		check(rd, 32'hA5A5_1234, "pri read");
		check({31'h0, snap_rw}, 32'h1, "rw read");
		// io strobe: single signal, one beat, slower cycle
		xfer(1'b0, 1'b0, 24'h81_0000, 32'h0);
		check({31'h0, snap_io}, 32'h0, "io strobe");
		check({28'h0, snap_pri & snap_sec}, 32'hF, "io alone");
		check(beats, 1, "io beats");
		check(lat, lat_pri + 1, "io latency");
		// internal ram never reaches the pins; unmapped hole answers with an error
		xfer(1'b1, 1'b0, 24'h87_FE00, 32'h1357_9BDF);
		xfer(1'b0, 1'b0, 24'h87_FE00, 32'h0);
		check(rd, 32'h1357_9BDF, "ram read");
		check(beats, 0, "ram beats");
		xfer(1'b0, 1'b0, 24'h80_0000, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped");
		// secondary 16-bit memory with 32-bit data: two beats
		cfg(1'b1, WID_16, WID_32);
		xfer(1'b1, 1'b0, 24'h90_0004, 32'hCAFE_F00D);
		check(beats, 2, "half beats");
		check({28'h0, snap_sec}, 32'hC, "half lanes");
		xfer(1'b0, 1'b0, 24'h90_0004, 32'h0);
		check(rd, 32'hCAFE_F00D, "half read");
		// secondary 8-bit memory: lanes 3,2 carry address bits
		cfg(1'b1, WID_8, WID_8);
		xfer(1'b1, 1'b0, 24'h90_0003, 32'h0000_005A);
		check({28'h0, snap_sec}, 32'hE, "byte lanes");
		xfer(1'b0, 1'b0, 24'h90_0003, 32'h0);
		check({24'h0, rd[7:0]}, 32'h5A, "byte read");
		// 32-bit memory holding bytes: byte 5 sits in word 1, lane 1
		cfg(1'b0, WID_32, WID_8);
		xfer(1'b1, 1'b0, 24'h00_0005, 32'h0000_00C3);
		check({28'h0, snap_pri}, 32'hD, "lane 1");
		check({8'h0, snap_addr}, 32'h1, "byte word");
		cfg(1'b0, WID_32, WID_32);
		// program width pin: 16-bit fetch in two beats, 32-bit fetch in one
		@(posedge ref_clk);
		pgm_w <= 1'b1;
		xfer(1'b0, 1'b1, 24'h00_0010, 32'h0);
		check(beats, 2, "fetch 16");
		@(posedge ref_clk);
		pgm_w <= 1'b0;
		xfer(1'b0, 1'b1, 24'h00_0010, 32'h0);
		check(beats, 1, "fetch 32");
		check(rd, 32'hA5A5_1234, "fetch word");
		// slow ready stretches the cycle
		@(posedge ref_clk);
		dly <= 4'h6;
		xfer(1'b0, 1'b0, 24'h00_0010, 32'h0);
		check({31'h0, lat > lat_pri + 3}, 32'h1, "ready wait");
		@(posedge ref_clk);
		dly <= 4'h1;
		// hold request floats the bus and grants
		@(posedge ref_clk);
		hold_b <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check({29'h0, grant_b, bus_oe, data_oe}, 32'h0, "hold");
		@(posedge ref_clk);
		hold_b <= 1'b1;
		repeat (3) @(negedge ref_clk);
		check({31'h0, grant_b}, 32'h1, "hold off");
		// deep idle freezes phase clocks until an interrupt
		@(posedge ref_clk);
		deep <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check({30'h0, h1, h3}, 32'h2, "idle clocks");
		check({28'h0, pri_b}, 32'hF, "idle bus");
		@(posedge ref_clk);
		irq <= 4'h4;
		deep <= 1'b0;
		@(posedge ref_clk);
		irq <= 4'h0;
		xfer(1'b0, 1'b0, 24'h00_0010, 32'h0);
		check(rd, 32'hA5A5_1234, "after idle");
		// reduced clock still completes bus cycles, slowly
		@(posedge ref_clk);
		reduced <= 1'b1;
		xfer(1'b0, 1'b0, 24'h00_0010, 32'h0);
		check({31'h0, lat >= 16}, 32'h1, "slow lat");
		check(rd, 32'hA5A5_1234, "slow read");
		@(posedge ref_clk);
		reduced <= 1'b0;
		pgm_w <= 1'b1;
		do_reset();
		close_out();
	end
endmodule : emsi_top_tb
